// [logic/tsr_trigger_route.sv]
`timescale 1ns/1ps
`include "tsr_defines.svh"

// Notes on behaviour
// - Bit 31 of each route register is a freeze bit that software can set but not clear, and only reset clears it.
// - While the freeze bit is one every write to that register is ignored, otherwise writes update the fields.
// - The timer route register has four 7-bit selectors at 30:24, 22:16, 14:8 and 6:0 for timer triggers 3..0.
// - The timer route register resets to 1e1e1e1e.
// - The multifunction route register has four 7-bit selectors for multifunction triggers 3..0 and resets to zero.
// - The first tick route register has one selector at 6:0 driving controller 0 tick and resets to 3a.
// - The second tick route register at offset 40 has one selector at 6:0 driving controller 1 tick, reset 3a.
module tsr_trigger_route (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [127:0] trig_src_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic [3:0] timer_a_internal_trigger_o,
    output logic [3:0] multifunc_timer_trigger_o,
    output logic ctrl0_ext_timestamp_tick_o,
    output logic ctrl1_ext_timestamp_tick_o
);
    import tsr_pkg::*;

    tsr_wb_req_t req;
    tsr_bus_state_t state_reg, state_next;
    logic [31:0] route_reg [4];
    logic [31:0] route_next [4];
    logic [31:0] rdat_reg, rdat_next;
    logic ack_reg, ack_next;
    logic err_reg, err_next;
    logic [2:0] hit;
    logic [6:0] sel_vec [10];
    logic [9:0] mux_out;

    function automatic logic [2:0] decode(input logic [7:0] adr);
        if (adr == `TSR_OFF_TIMER_A) begin
            decode = 3'h0;
        end else if (adr == `TSR_OFF_MFIO) begin
            decode = 3'h1;
        end else if (adr == `TSR_OFF_CTRL0) begin
            decode = 3'h2;
        end else if (adr == `TSR_OFF_CTRL1) begin
            decode = 3'h3;
        end else begin
            decode = 3'h4;
        end
    endfunction

    // Reserved bits always read and store as zero
    function automatic logic [31:0] field_mask(input logic [2:0] idx);
        field_mask = (idx < 3'h2) ? `TSR_QUAD_MASK : `TSR_SINGLE_MASK;
    endfunction

    always_comb begin
        req.cyc = wb_cyc_i;
        req.stb = wb_stb_i;
        req.we = wb_we_i;
        req.sel = wb_sel_i;
        req.adr = wb_adr_i;
        req.dat = wb_dat_i;
        hit = decode(req.adr);
    end

    // One wait state; ack drops the cycle after it is given so the master can release
    always_comb begin
        state_next = state_reg;
        ack_next = 1'b0;
        err_next = 1'b0;
        rdat_next = rdat_reg;
        for (int i = 0; i < `TSR_NUM_ROUTES; i++) begin
            route_next[i] = route_reg[i];
        end
        case (state_reg)
            TSR_IDLE: begin
                if (req.cyc && req.stb) begin
                    state_next = TSR_ACK;
                    // Partial-word access is refused, the registers are word only
                    if (hit == 3'h4 || req.sel != 4'hf) begin
                        err_next = 1'b1;
                        rdat_next = 32'h00000000;
                    end else begin
                        ack_next = 1'b1;
                        rdat_next = route_reg[hit[1:0]];
                        if (req.we && !route_reg[hit[1:0]][`TSR_FREEZE_BIT]) begin
                            // Freeze bit comes from the written data; a zero never clears it because writes are blocked while it is set
                            route_next[hit[1:0]] = (req.dat & field_mask(hit)) |
                                (req.dat & 32'h80000000);
                        end
                    end
                end
            end
            TSR_ACK: begin
                state_next = TSR_IDLE;
            end
            default: begin
                state_next = TSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= TSR_IDLE;
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdat_reg <= 32'h00000000;
            route_reg[0] <= `TSR_RST_TIMER_A;
            route_reg[1] <= `TSR_RST_MFIO;
            route_reg[2] <= `TSR_RST_CTRL0;
            route_reg[3] <= `TSR_RST_CTRL1;
        end else begin
            state_reg <= state_next;
            ack_reg <= ack_next;
            err_reg <= err_next;
            rdat_reg <= rdat_next;
            for (int i = 0; i < `TSR_NUM_ROUTES; i++) begin
                route_reg[i] <= route_next[i];
            end
        end
    end

    always_comb begin
        sel_vec[0] = route_reg[0][6:0];
        sel_vec[1] = route_reg[0][14:8];
        sel_vec[2] = route_reg[0][22:16];
        sel_vec[3] = route_reg[0][30:24];
        sel_vec[4] = route_reg[1][6:0];
        sel_vec[5] = route_reg[1][14:8];
        sel_vec[6] = route_reg[1][22:16];
        sel_vec[7] = route_reg[1][30:24];
        sel_vec[8] = route_reg[2][6:0];
        sel_vec[9] = route_reg[3][6:0];
    end

    // Outputs are registered, so a route lags its source by one clock
    for (genvar g = 0; g < 10; g++) begin : g_mux
        tsr_route_mux u_mux (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .src_i(trig_src_i),
            .sel_i(sel_vec[g]),
            .out_o(mux_out[g])
        );
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = rdat_reg;
    assign timer_a_internal_trigger_o = mux_out[3:0];
    assign multifunc_timer_trigger_o = mux_out[7:4];
    assign ctrl0_ext_timestamp_tick_o = mux_out[8];
    assign ctrl1_ext_timestamp_tick_o = mux_out[9];

    logic fire;
    assign fire = wb_cyc_i && wb_stb_i && state_reg == TSR_IDLE && wb_sel_i == 4'hf && wb_we_i;

    a_freeze_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        route_reg[0][31] |=> route_reg[0][31]) else $error("timer route freeze bit cleared");
    a_freeze_sticky_c1: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(route_reg[3][31]) |-> route_reg[3][31]) else $error("tick1 freeze bit cleared");
    a_frozen_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        route_reg[1][31] |=> $stable(route_reg[1])) else $error("frozen route changed");
    a_write_takes: assert property (@(posedge clk_i) disable iff (rst_i)
        fire && wb_adr_i == 8'h34 && !route_reg[0][31] |=> route_reg[0] == ($past(wb_dat_i) & 32'hff7f7f7f))
        else $error("timer route write lost");
    a_timer_sel3: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 ($past(rst_i) || timer_a_internal_trigger_o[3] == $past(trig_src_i[route_reg[0][30:24]])))
        else $error("timer trigger 3 misrouted");
    a_mfio_sel1: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 ($past(rst_i) || multifunc_timer_trigger_o[1] == $past(trig_src_i[route_reg[1][14:8]])))
        else $error("multifunction trigger 1 misrouted");
    a_tick0_route: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 ($past(rst_i) || ctrl0_ext_timestamp_tick_o == $past(trig_src_i[route_reg[2][6:0]])))
        else $error("tick 0 misrouted");
    a_tick1_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
        route_reg[3][30:7] == 24'h000000) else $error("tick 1 reserved bits set");
    a_reset_value: assert property (@(posedge clk_i)
        rst_i |=> route_reg[0] == 32'h1e1e1e1e && route_reg[2] == 32'h0000003a)
        else $error("wrong reset value");
    a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held over two cycles");

    c_write: cover property (@(posedge clk_i) disable iff (rst_i) fire ##1 wb_ack_o);
    c_frozen: cover property (@(posedge clk_i) disable iff (rst_i) fire && route_reg[0][31]);
    c_error: cover property (@(posedge clk_i) disable iff (rst_i) wb_err_o);
endmodule

// [logic/tsr_defines.svh]
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH

`define TSR_ADDR_W 8
`define TSR_OFF_TIMER_A 8'h34
`define TSR_OFF_MFIO 8'h38
`define TSR_OFF_CTRL0 8'h3c
`define TSR_OFF_CTRL1 8'h40
`define TSR_RST_TIMER_A 32'h1e1e1e1e
`define TSR_RST_MFIO 32'h00000000
`define TSR_RST_CTRL0 32'h0000003a
`define TSR_RST_CTRL1 32'h0000003a
`define TSR_FREEZE_BIT 31
`define TSR_SEL_W 7
`define TSR_SRC_N 128
`define TSR_QUAD_MASK 32'h7f7f7f7f
`define TSR_SINGLE_MASK 32'h0000007f
`define TSR_NUM_ROUTES 4

`endif

// [logic/tsr_pkg.sv]
package tsr_pkg;
    typedef logic [6:0] tsr_sel_t;

    typedef struct packed {
        logic freeze;
        tsr_sel_t sel3;
        tsr_sel_t sel2;
        tsr_sel_t sel1;
        tsr_sel_t sel0;
    } tsr_route_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } tsr_wb_req_t;

    typedef struct packed {
        logic [3:0] timer_a;
        logic [3:0] mfio;
        logic ctrl0_tick;
        logic ctrl1_tick;
    } tsr_trig_out_t;

    typedef enum logic [1:0] {
        TSR_IDLE = 2'b01,
        TSR_ACK = 2'b10
    } tsr_bus_state_t;
endpackage

// [logic/tsr_route_mux.sv]
`timescale 1ns/1ps
`include "tsr_defines.svh"

// Registered selection of one source out of the source vector
module tsr_route_mux (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [127:0] src_i,
    input wire logic [6:0] sel_i,
    output logic out_o
);
    logic out_reg;
    logic out_next;

    always_comb begin
        out_next = src_i[sel_i];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
        end
    end

    assign out_o = out_reg;
endmodule

// [tb/tsr_src_model.sv]
`timescale 1ns/1ps
// Far-side trigger sources; a rotating pattern so each index toggles and a wrong pick shows quickly
module tsr_src_model (
    input wire logic clk_i,
    output logic [127:0] src_o
);
    initial src_o = 128'h0123456789abcdef_fedcba9876543210;
    always @(posedge clk_i) begin
        src_o <= {src_o[126:0], src_o[127]};
    end
endmodule

// [tb/tb_tsr_trigger_route.sv]
`timescale 1ns/1ps
module tb_tsr_trigger_route;
    localparam logic [7:0] ADR [4] = '{8'h34, 8'h38, 8'h3c, 8'h40};
    localparam logic [31:0] RST [4] = '{32'h1e1e1e1e, 32'h00000000, 32'h0000003a, 32'h0000003a};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'hf;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h00000000;
    logic [127:0] src;
    logic [31:0] dat_o;
    logic ack, err, c0, c1;
    logic [3:0] ta, mf;
    logic [31:0] rd;
    logic er;
    logic [31:0] exp_reg [4];
    int error_cnt = 0;
    int total_checks = 0;

    tsr_src_model u_tsr_src_model (.clk_i(clk_i), .src_o(src));
    tsr_trigger_route u_tsr_trigger_route (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .trig_src_i(src), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(err), .timer_a_internal_trigger_o(ta), .multifunc_timer_trigger_o(mf),
        .ctrl0_ext_timestamp_tick_o(c0), .ctrl1_ext_timestamp_tick_o(c1));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Every cycle starts on an edge, so cyc and stb stay low for a cycle between cycles
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        // No wait-state count is assumed; only the watchdog ends a hung cycle
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1 && err !== 1'b1);
        rd = dat_o;
        er = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        check({er, rd[30:0]}, {1'b0, exp[30:0]});
        check(rd, exp);
    endtask

    task automatic routes(input int n);
        logic [127:0] s;
        logic [9:0] e;
        repeat (n) begin
            @(posedge clk_i);
            s = src;
            e = {s[exp_reg[0][30:24]], s[exp_reg[0][22:16]], s[exp_reg[0][14:8]], s[exp_reg[0][6:0]],
                s[exp_reg[1][30:24]], s[exp_reg[1][22:16]], s[exp_reg[1][14:8]], s[exp_reg[1][6:0]],
                s[exp_reg[2][6:0]], s[exp_reg[3][6:0]]};
            #1;
            check({22'h0, ta, mf, c0, c1}, {22'h0, e});
        end
    endtask

    task automatic t_write();
        exp_reg = '{32'h05400a7f, 32'h7e002301, 32'h00000000, 32'h0000007f};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, ADR[i], exp_reg[i], 4'hf);
            rdchk(ADR[i], exp_reg[i]);
        end
        routes(8);
    endtask

    task automatic t_errors();
        bus(1'b0, 8'h44, 32'h0, 4'hf);
        check({31'h0, er}, 32'h1);
        bus(1'b1, ADR[0], 32'h0, 4'h3);
        check({31'h0, er}, 32'h1);
        rdchk(ADR[0], exp_reg[0]);
    endtask

    task automatic t_freeze();
        for (int i = 0; i < 4; i++) begin
            exp_reg[i][31] = 1'b1;
            bus(1'b1, ADR[i], exp_reg[i], 4'hf);
            rdchk(ADR[i], exp_reg[i]);
            bus(1'b1, ADR[i], 32'h00000000, 4'hf);
            rdchk(ADR[i], exp_reg[i]);
        end
        routes(4);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        exp_reg = RST;
        for (int i = 0; i < 4; i++) begin
            rdchk(ADR[i], RST[i]);
        end
        routes(4);
    endtask

    task automatic results();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #(3000 * 100);
        error_cnt++;
        results();
    end

    initial begin
        exp_reg = RST;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rdchk(ADR[i], RST[i]);
        end
        routes(4);
        t_write();
        t_errors();
        t_freeze();
        results();
    end
endmodule
